// >>> fss_top.v
// Fuse and signature store with live configuration latch
`timescale 1ns/1ns
`default_nettype none
`include "fss_defines.vh"

module fss_top (
	// Clock and reset
	input  wire       i_clk,
	input  wire       i_rstn,
	// Mode
	input  wire       i_prog_mode,
	input  wire       i_serial_path,
	// Programmer commands
	input  wire       i_fuse_wr,
	input  wire [1:0] i_fuse_sel,
	input  wire [7:0] i_fuse_wdata,
	input  wire       i_lock_wr,
	input  wire [7:0] i_lock_wdata,
	input  wire       i_chip_erase,
	input  wire       i_fuse_rd,
	input  wire       i_lock_rd,
	input  wire       i_sig_rd,
	input  wire [1:0] i_sig_addr,
	input  wire       i_sig_hi,
	// Read answer
	output reg  [7:0] o_rdata,
	output reg        o_rvalid,
	output reg        o_wr_refused,
	// Oscillator trim
	output reg  [7:0] o_osc_trim_reg,
	// Live configuration
	output reg  [7:0] o_live_low,
	output reg  [7:0] o_live_high,
	output reg  [7:0] o_live_ext,
	output reg        o_eeprom_keep_on_erase,
	output reg        o_clk_to_pin,
	output reg        o_onchip_debug_en,
	output reg        o_sel_rc8m,
	output reg        o_boot_largest
);

	// ----------------------------------------
	// Boot sequence states
	// ----------------------------------------
	localparam [0:0] BOOT_LOAD = 1'b0;	// First edge after reset release
	localparam [0:0] BOOT_RUN  = 1'b1;	// Steady operation

	// ----------------------------------------
	// Nonvolatile store, modelled as bits that no reset touches
	// ----------------------------------------
	reg  [7:0] low_config_byte_r;
	reg  [7:0] high_config_byte_r;
	reg  [7:0] extended_config_byte_r;
	reg  [7:0] lock_r;
	reg        nv_init_r;

	// ----------------------------------------
	// Volatile state and next values
	// ----------------------------------------
	reg        prog_d_r;
	reg  [0:0] boot_state_r;
	reg  [0:0] boot_state_nxt;
	reg  [7:0] rdata_nxt;
	reg        rvalid_nxt;
	reg        refused_nxt;
	reg  [7:0] wval;

	// ----------------------------------------
	// Qualified requests
	// ----------------------------------------
	wire [7:0] sig_data;
	wire [7:0] cal_data;
	wire       locked;
	wire       prog_rise;
	wire       boot_load;
	wire       latch_live;
	wire       erase_take;
	wire       lock_wr_take;
	wire       fuse_wr_take;
	wire       fuse_wr_ok;
	wire       fuse_wr_bad;
	wire       rd_take;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// A fuse or lock bit reads 0 when programmed
	function is_prog;
		input fuse_bit;
		begin
			is_prog = ~fuse_bit;
		end
	endfunction

	function [7:0] fuse_pick;
		input [1:0] sel;
		begin
			case (sel)
				`FSS_SEL_LOW:  fuse_pick = low_config_byte_r;
				`FSS_SEL_HIGH: fuse_pick = high_config_byte_r;
				`FSS_SEL_EXT:  fuse_pick = extended_config_byte_r;
				default:       fuse_pick = 8'hff;
			endcase
		end
	endfunction

	// ----------------------------------------
	// Request qualification
	// ----------------------------------------
	assign locked       = is_prog(lock_r[`FSS_LOCK_ONE_BIT]);
	assign prog_rise    = i_prog_mode & ~prog_d_r;
	assign boot_load    = (boot_state_r == BOOT_LOAD);
	assign latch_live   = prog_rise | (boot_load & ~i_prog_mode);
	assign erase_take   = i_prog_mode & i_chip_erase;
	assign lock_wr_take = i_prog_mode & i_lock_wr & ~i_chip_erase;
	assign fuse_wr_take = i_prog_mode & i_fuse_wr;
	// Erase in the same cycle wins over a fuse write
	assign fuse_wr_ok   = fuse_wr_take & ~locked & ~i_chip_erase;
	assign fuse_wr_bad  = fuse_wr_take & locked;
	assign rd_take      = i_prog_mode & (i_fuse_rd | i_lock_rd | i_sig_rd);

	// ----------------------------------------
	// Signature row lookups
	// ----------------------------------------
	fss_sig_rom u_rom (
		.i_addr (i_sig_addr),
		.i_hi   (i_sig_hi),
		.o_data (sig_data)
	);

	// Second lookup fixed on the calibration slot, so the trim load
	// never depends on what the programmer addresses
	fss_sig_rom u_cal_rom (
		.i_addr (`FSS_SIG_ADDR_0),
		.i_hi   (1'b1),
		.o_data (cal_data)
	);

	// ----------------------------------------
	// Write data shaping
	// ----------------------------------------
	always @* begin
		wval = i_fuse_wdata;
		if (i_serial_path && i_fuse_sel == `FSS_SEL_HIGH)
			wval[`FSS_HIGH_SPROG_BIT] = high_config_byte_r[`FSS_HIGH_SPROG_BIT];
		if (i_fuse_sel == `FSS_SEL_EXT)
			wval = (i_fuse_wdata & `FSS_EXT_USED_MASK);
	end

	// ----------------------------------------
	// Store initialisation
	// ----------------------------------------
	// Delivered values are loaded on the first clock only; reset never
	// reaches the store, so programmed fuses survive it
	initial nv_init_r = 1'b0;
	always @(posedge i_clk) begin
		nv_init_r <= 1'b1;
	end

	// ----------------------------------------
	// Fuse bytes
	// ----------------------------------------
	always @(posedge i_clk) begin
		if (!nv_init_r)
			low_config_byte_r <= `FSS_LOW_RESET;
		else if (fuse_wr_ok && i_fuse_sel == `FSS_SEL_LOW)
			low_config_byte_r <= wval;
	end

	always @(posedge i_clk) begin
		if (!nv_init_r)
			high_config_byte_r <= `FSS_HIGH_RESET;
		else if (fuse_wr_ok && i_fuse_sel == `FSS_SEL_HIGH)
			high_config_byte_r <= wval;
	end

	always @(posedge i_clk) begin
		if (!nv_init_r)
			extended_config_byte_r <= `FSS_EXT_RESET;
		else if (fuse_wr_ok && i_fuse_sel == `FSS_SEL_EXT)
			extended_config_byte_r <= wval;
	end

	// ----------------------------------------
	// Lock byte
	// ----------------------------------------
	// Lock bits only move toward programmed; erase is the way back
	always @(posedge i_clk) begin
		if (!nv_init_r)
			lock_r <= `FSS_LOCK_RESET;
		else if (erase_take)
			lock_r <= `FSS_LOCK_RESET;
		else if (lock_wr_take)
			lock_r <= lock_r & i_lock_wdata;
	end

	// ----------------------------------------
	// Boot sequence
	// ----------------------------------------
	always @* begin
		boot_state_nxt = boot_state_r;
		case (boot_state_r)
			BOOT_LOAD: boot_state_nxt = BOOT_RUN;
			BOOT_RUN:  boot_state_nxt = BOOT_RUN;
			default:   boot_state_nxt = BOOT_LOAD;
		endcase
	end

	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			boot_state_r <= BOOT_LOAD;
			prog_d_r     <= 1'b0;
		end else begin
			boot_state_r <= boot_state_nxt;
			prog_d_r     <= i_prog_mode;
		end
	end

	// ----------------------------------------
	// Oscillator trim
	// ----------------------------------------
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			o_osc_trim_reg <= 8'h00;
		else if (boot_load)
			o_osc_trim_reg <= cal_data;
	end

	// ----------------------------------------
	// Live configuration latch
	// ----------------------------------------
	// Fuse writes during programming stay invisible here until the
	// next latch event
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_live_low  <= `FSS_LOW_RESET;
			o_live_high <= `FSS_HIGH_RESET;
			o_live_ext  <= `FSS_EXT_RESET;
		end else if (latch_live) begin
			o_live_low  <= low_config_byte_r;
			o_live_high <= high_config_byte_r;
			o_live_ext  <= extended_config_byte_r;
		end
	end

	// ----------------------------------------
	// Keep-on-erase, straight from the store
	// ----------------------------------------
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			o_eeprom_keep_on_erase <= 1'b0;
		else
			o_eeprom_keep_on_erase <= is_prog(high_config_byte_r[`FSS_HIGH_KEEP_BIT]);
	end

	// ----------------------------------------
	// Decodes of the live bytes
	// ----------------------------------------
	// Reset values follow the delivered bytes that the live latch shows
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_clk_to_pin      <= 1'b0;
			o_onchip_debug_en <= 1'b0;
			o_sel_rc8m        <= 1'b1;
			o_boot_largest    <= 1'b1;
		end else begin
			o_clk_to_pin      <= is_prog(o_live_low[`FSS_LOW_CLK_TO_PIN_BIT]);
			o_onchip_debug_en <= is_prog(o_live_high[`FSS_HIGH_OCD_BIT]);
			o_sel_rc8m        <= (o_live_low[3:0] == `FSS_CKSRC_RC8M);
			o_boot_largest    <= (o_live_high[2:1] == 2'b00);
		end
	end

	// ----------------------------------------
	// Read and refusal answers
	// ----------------------------------------
	// Signature reads win, then lock, then fuse; data holds between reads
	always @* begin
		rdata_nxt   = o_rdata;
		rvalid_nxt  = rd_take;
		refused_nxt = fuse_wr_bad;
		if (rd_take) begin
			if (i_sig_rd)
				rdata_nxt = sig_data;
			else if (i_lock_rd)
				rdata_nxt = lock_r;
			else
				rdata_nxt = fuse_pick(i_fuse_sel);
		end
	end

	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rdata      <= 8'h00;
			o_rvalid     <= 1'b0;
			o_wr_refused <= 1'b0;
		end else begin
			o_rdata      <= rdata_nxt;
			o_rvalid     <= rvalid_nxt;
			o_wr_refused <= refused_nxt;
		end
	end

endmodule
`default_nettype wire

// >>> fss_defines.vh
// Constants for the fuse and signature store
`ifndef FSS_DEFINES_VH
`define FSS_DEFINES_VH

// ----------------------------------------
// Signature space addresses
// ----------------------------------------
`define FSS_SIG_ADDR_0      2'h0
`define FSS_SIG_ADDR_1      2'h1
`define FSS_SIG_ADDR_2      2'h2

// ----------------------------------------
// Fuse byte select codes
// ----------------------------------------
`define FSS_SEL_LOW         2'h0
`define FSS_SEL_HIGH        2'h1
`define FSS_SEL_EXT         2'h2

// ----------------------------------------
// Delivered values
// ----------------------------------------
`define FSS_LOW_RESET       8'h62
`define FSS_HIGH_RESET      8'h99
`define FSS_EXT_RESET       8'h07
`define FSS_EXT_USED_MASK   8'h07
`define FSS_LOCK_RESET      8'hff

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FSS_LOW_DIV8_BIT    7
`define FSS_LOW_CLK_TO_PIN_BIT   6
`define FSS_HIGH_OCD_BIT    7
`define FSS_HIGH_SCAN_BIT   6
`define FSS_HIGH_SPROG_BIT  5
`define FSS_HIGH_WDT_BIT    4
`define FSS_HIGH_KEEP_BIT   3
`define FSS_HIGH_BOOT_BIT   0
`define FSS_LOCK_ONE_BIT    0

// ----------------------------------------
// Clock source codes
// ----------------------------------------
`define FSS_CKSRC_RC8M      4'h2

`endif

// >>> fss_sig_rom.v
// Read-only signature row: identification bytes and calibration byte
`timescale 1ns/1ns
`default_nettype none
`include "fss_defines.vh"

module fss_sig_rom #(
	parameter [7:0] ID_BYTE_0 = 8'ha5,	// Arbitrary value
	parameter [7:0] ID_BYTE_1 = 8'h5a,	// Arbitrary value
	parameter [7:0] ID_BYTE_2 = 8'h3c,	// Arbitrary value
	parameter [7:0] CAL_BYTE  = 8'h80	// Arbitrary value
) (
	// Lookup
	input  wire [1:0] i_addr,
	input  wire       i_hi,
	output reg  [7:0] o_data
);

	// ----------------------------------------
	// Decode, independent of lock state
	// ----------------------------------------
	always @* begin
		o_data = 8'hff;
		if (i_hi) begin
			if (i_addr == `FSS_SIG_ADDR_0)
				o_data = CAL_BYTE;
		end else begin
			case (i_addr)
				`FSS_SIG_ADDR_0: o_data = ID_BYTE_0;
				`FSS_SIG_ADDR_1: o_data = ID_BYTE_1;
				`FSS_SIG_ADDR_2: o_data = ID_BYTE_2;
				default:         o_data = 8'hff;
			endcase
		end
	end

endmodule
`default_nettype wire

// >>> fss_top_asserts.sv
// Checker for the fuse and signature store ports
`timescale 1ns/1ns
`default_nettype none
module fss_top_asserts (
	input wire logic       i_clk, i_rstn, i_prog_mode, i_fuse_wr, i_chip_erase,
	input wire logic       i_fuse_rd, i_lock_rd, i_sig_rd,
	input wire logic [1:0] i_fuse_sel,
	input wire logic [7:0] i_fuse_wdata, o_live_low, o_live_high,
	input wire logic       o_rvalid, o_wr_refused, o_eeprom_keep_on_erase,
	input wire logic       o_clk_to_pin, o_onchip_debug_en, o_sel_rc8m, o_boot_largest
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	a_rd_answer: assert property (
		i_prog_mode && (i_fuse_rd || i_lock_rd || i_sig_rd) |=> o_rvalid)
		else $error("read not answered");
	a_refuse_cause: assert property (
		o_wr_refused |-> $past(i_fuse_wr && i_prog_mode))
		else $error("refusal without fuse write");
	a_live_hold: assert property (
		i_prog_mode && $past(i_prog_mode) && $past(i_prog_mode, 2)
		|-> $stable(o_live_low) && $stable(o_live_high))
		else $error("live bytes moved in programming mode");
	a_keep_now: assert property (
		i_prog_mode && i_fuse_wr && !i_chip_erase && i_fuse_sel == 2'h1 && !i_fuse_wdata[3]
		##1 !o_wr_refused |-> ##[0:1] o_eeprom_keep_on_erase)
		else $error("keep fuse not effective");
	a_clk_pin: assert property (o_clk_to_pin == !$past(o_live_low[6]))
		else $error("clock pin decode wrong");
	a_rc_source: assert property (o_sel_rc8m == ($past(o_live_low[3:0]) == 4'h2))
		else $error("clock source decode wrong");
	a_boot_size: assert property (o_boot_largest == ($past(o_live_high[2:1]) == 2'h0))
		else $error("boot size decode wrong");
	a_debug_en: assert property (o_onchip_debug_en == !$past(o_live_high[7]))
		else $error("debug decode wrong");
endmodule
`default_nettype wire

// >>> fss_prog_model.sv
// Programmer model driving the store's command pins
`timescale 1ns/1ns
`default_nettype none
module fss_prog_model (
	input  wire logic       i_clk,
	output var  logic       i_prog_mode, i_serial_path, i_fuse_wr, i_lock_wr, i_chip_erase,
	output var  logic       i_fuse_rd, i_lock_rd, i_sig_rd, i_sig_hi,
	output var  logic [1:0] i_fuse_sel, i_sig_addr,
	output var  logic [7:0] i_fuse_wdata, i_lock_wdata
);
	initial {i_prog_mode, i_serial_path, i_fuse_wr, i_lock_wr, i_chip_erase, i_fuse_rd,
		i_lock_rd, i_sig_rd, i_sig_hi, i_fuse_sel, i_sig_addr, i_fuse_wdata, i_lock_wdata} = '0;
	task mode(input logic p, input logic s);
		@(posedge i_clk);
		{i_prog_mode, i_serial_path} <= {p, s};
	endtask
	// One pulse command; data is scrambled once the pulse is over
	task cmd(input logic [5:0] r, input logic [1:0] s, input logic [7:0] d);
		@(posedge i_clk);
		{i_fuse_wr, i_lock_wr, i_chip_erase, i_fuse_rd, i_lock_rd, i_sig_rd} <= r;
		{i_fuse_sel, i_sig_addr, i_sig_hi} <= {s, s, d[0]};
		{i_fuse_wdata, i_lock_wdata} <= {d, d};
		@(posedge i_clk);
		{i_fuse_wr, i_lock_wr, i_chip_erase, i_fuse_rd, i_lock_rd, i_sig_rd} <= 6'h0;
		{i_fuse_wdata, i_lock_wdata} <= ~{d, d};
		#1;
	endtask
endmodule
`default_nettype wire

// >>> fss_top_bench.sv
// Self-checking bench for the fuse and signature store
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin bad_count++; \
	$display("FAIL %s exp %h got %h", n, e, a); end end
module fss_top_bench;
	logic       i_clk, i_rstn;
	wire        i_prog_mode, i_serial_path, i_fuse_wr, i_lock_wr, i_chip_erase;
	wire        i_fuse_rd, i_lock_rd, i_sig_rd, i_sig_hi, o_rvalid, o_wr_refused;
	wire        o_eeprom_keep_on_erase, o_clk_to_pin, o_onchip_debug_en;
	wire        o_sel_rc8m, o_boot_largest;
	wire [1:0]  i_fuse_sel, i_sig_addr;
	wire [7:0]  i_fuse_wdata, i_lock_wdata, o_rdata, o_osc_trim_reg;
	wire [7:0]  o_live_low, o_live_high, o_live_ext;
	int         bad_count, compares;
	// Rows: request, select, data, expected read or refusal
	logic [31:0] rows [23] = '{
		32'h04000062, 32'h04010099, 32'h04020007,
		32'h020000ff, 32'h010000a5, 32'h0101005a, 32'h0102003c,
		32'h01000180, 32'h010300ff, 32'h20002200, 32'h04000022,
		32'h20019100, 32'h08000000, 32'h04000022,
		32'h2002ff00, 32'h04020007,
		32'h1000fe00, 32'h020000fe, 32'h2000ff01, 32'h04000022,
		32'h010000a5, 32'h08000000, 32'h020000ff};
	fss_top u_fss_top (.*);
	fss_prog_model u_fss_prog_model (.*);
	initial begin
		i_clk = 0;
		forever #5 i_clk = ~i_clk;
	end
	task stop_test;
		$display("mismatches %0d compares %0d", bad_count, compares);
		if (bad_count == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task do_reset;
		@(posedge i_clk) i_rstn <= 0;
		repeat (3) @(posedge i_clk);
		i_rstn <= 1;
		repeat (2) @(posedge i_clk);
		#1;
	endtask
	initial begin
		#20000;
		bad_count++;
		stop_test;
	end
	initial begin
		i_rstn = 0;
		do_reset;
		`CHK("trim", 8'h80, o_osc_trim_reg)
		`CHK("live", 24'h629907, {o_live_low, o_live_high, o_live_ext})
		`CHK("decode", 4'h3, {o_clk_to_pin, o_onchip_debug_en, o_sel_rc8m, o_boot_largest})
		u_fss_prog_model.mode(1, 0);
		foreach (rows[i]) begin
			u_fss_prog_model.cmd(rows[i][29:24], rows[i][17:16], rows[i][15:8]);
			if (rows[i][26:24] != 0) `CHK("rdata", {1'b1, rows[i][7:0]}, {o_rvalid, o_rdata})
			else `CHK("refused", rows[i][0], o_wr_refused)
		end
		`CHK("hold", 8'h62, o_live_low)
		`CHK("keep", 1'b1, o_eeprom_keep_on_erase)
		u_fss_prog_model.mode(1, 1);
		u_fss_prog_model.cmd(6'h20, 2'h1, 8'hb1);
		u_fss_prog_model.mode(1, 0);
		u_fss_prog_model.cmd(6'h04, 2'h1, 8'h00);
		`CHK("serial", 8'h91, o_rdata)
		u_fss_prog_model.mode(0, 0);
		do_reset;
		`CHK("latch", 24'h229107, {o_live_low, o_live_high, o_live_ext})
		`CHK("trim again", 8'h80, o_osc_trim_reg)
		`CHK("pin", 1'b1, o_clk_to_pin)
		stop_test;
	end
endmodule
bind fss_top fss_top_asserts u_fss_top_asserts (.*);
`default_nettype wire
